// [lsc_pkg.sv]
package lsc_pkg;

    // Clock rate and time figures
    localparam int unsigned CLOCK_HZ      = 40_000_000;        // System clock, 25 ns period
    localparam int unsigned SECOND_S      = 1;                 // Delay step, seconds
    localparam int unsigned SEC_CYCLES    = CLOCK_HZ * SECOND_S;
    localparam int unsigned ALARM_TIME_MS = 500;               // Audible alarm length, ms
    localparam int unsigned ALARM_CYCLES  = (CLOCK_HZ / 1000) * ALARM_TIME_MS;

    // Register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_DELAY      = 8'h04;
    localparam logic [7:0] REG_VPROT      = 8'h08;
    localparam logic [7:0] REG_ILIM       = 8'h0c;
    localparam logic [7:0] REG_CUR_SET    = 8'h10;
    localparam logic [7:0] REG_PWR_SET    = 8'h14;
    localparam logic [7:0] REG_QCW_PERIOD = 8'h18;
    localparam logic [7:0] REG_QCW_WIDTH  = 8'h1c;
    localparam logic [7:0] REG_STATE      = 8'h20;
    localparam logic [7:0] REG_IRQ_STAT   = 8'h24;
    localparam logic [7:0] REG_IRQ_CLR    = 8'h28;
    localparam logic [7:0] REG_IRQ_EN     = 8'h2c;

    // Control register fields
    localparam int CTRL_POL_BIT  = 0;                          // 0 anode grounded, 1 cathode
    localparam int CTRL_MODE_BIT = 1;                          // 0 constant current, 1 power
    localparam int CTRL_INH_LSB  = 2;                          // Two-bit inhibit mode
    localparam int CTRL_QCW_BIT  = 4;                          // Pulse pattern enable
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // Inhibit mode codes
    localparam logic [1:0] INH_NONE = 2'h0;
    localparam logic [1:0] INH_AUTO = 2'h1;
    localparam logic [1:0] INH_PROT = 2'h2;

    // Programmable ranges and reset values
    localparam logic [5:0]  DELAY_MAX_S   = 6'h3c;             // 60 s
    localparam logic [5:0]  DELAY_RESET_S = 6'h03;             // 3 s
    localparam logic [15:0] VPROT_MIN_MV  = 16'h03e8;          // 1 V
    localparam logic [15:0] VPROT_MAX_MV  = 16'h2af8;          // 11 V
    localparam logic [15:0] ILIM_MIN_MA   = 16'h0005;          // 5 mA
    localparam logic [15:0] ILIM_MAX_MA   = 16'h13ba;          // 5.05 A model

    // Interrupt / status bits
    localparam int IRQ_ILK  = 0;                               // Interlock opened
    localparam int IRQ_ENF  = 1;                               // Enable input fault
    localparam int IRQ_OV   = 2;                               // Overvoltage trip
    localparam int IRQ_REF  = 3;                               // Switch-on refused or aborted
    localparam int IRQ_BITS = 4;

    // Output sequence states
    typedef enum logic [1:0] {ST_OFF, ST_DELAY, ST_ON} lsc_state_t;

endpackage : lsc_pkg

// [lsc_qcw_if.sv]
`timescale 1ns/1ps
interface lsc_qcw_if;
    logic        enable;                                       // Pattern runs while high
    logic [23:0] period;                                       // Cycles per pulse period
    logic [23:0] width;                                        // Cycles high per period
    logic        trig;                                         // Pattern level

    modport ctrl (output enable, output period, output width, input trig);
    modport gen  (input enable, input period, input width, output trig);
endinterface : lsc_qcw_if

// [lsc_sync.sv]
`timescale 1ns/1ps
module lsc_sync #(
    parameter int         WIDTH    = 2,
    parameter logic [1:0] RST_VAL  = 2'h0
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rstn,
    // Data
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage;                                   // First stage, read by q only

    // Two-flop synchroniser
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stage <= RST_VAL[WIDTH-1:0];
            q     <= RST_VAL[WIDTH-1:0];
        end else begin
            stage <= d;
            q     <= stage;
        end
    end
endmodule : lsc_sync

// [lsc_qcw.sv]
`timescale 1ns/1ps
module lsc_qcw (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rstn,
    // Pattern settings and level
    lsc_qcw_if.gen    qcw
);
    logic [23:0] count;                                        // Position in period

    // Period counter, held at zero while idle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count <= 24'h000000;
        end else if (!qcw.enable || count + 24'h000001 >= qcw.period) begin
            count <= 24'h000000;
        end else begin
            count <= count + 24'h000001;
        end
    end

    // Pattern level: high for the first width cycles of each period
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            qcw.trig <= 1'b0;
        end else begin
            qcw.trig <= qcw.enable && (count < qcw.width);
        end
    end
endmodule : lsc_qcw

// [lsc_top.sv]
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module lsc_top
    import lsc_pkg::*;
#(
    parameter int unsigned SEC_COUNT   = SEC_CYCLES,           // Cycles per delay second
    parameter int unsigned ALARM_COUNT = ALARM_CYCLES,         // Alarm length in cycles
    parameter logic [15:0] ILIM_TOP_MA = ILIM_MAX_MA           // Model current ceiling
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // Front panel
    input  wire logic        laser_on_key,
    input  wire logic        laser_off_key,
    // Field inputs
    input  wire logic        interlock_sense,
    input  wire logic        external_enable_input,
    input  wire logic [15:0] laser_voltage_mv,
    input  wire logic [15:0] feedback_value,
    // Outputs
    output logic             interlock_drive,
    output logic             key_led_red,
    output logic             alarm_beep,
    output logic             error_flag,
    output logic             drive_pin_cathode,
    output logic             drive_pin_anode,
    output logic      [15:0] drive_current_ma,
    output logic             trigger_out,
    output logic             irq
);
    // Clamp a written value into a range
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        if (v < lo) begin
            return lo;
        end else if (v > hi) begin
            return hi;
        end
        return v;
    endfunction : clamp16

    // Configuration registers
    logic [4:0]          ctrl;                                 // Polarity, mode, inhibit, qcw
    logic [5:0]          delay_s;                              // Switch-on delay, seconds
    logic [15:0]         vprot_mv;                             // Overvoltage threshold
    logic [15:0]         ilim_ma;                              // Current limit
    logic [15:0]         cur_set_ma;                           // Constant current setpoint
    logic [15:0]         pwr_set;                              // Feedback setpoint
    logic [23:0]         qcw_period;                           // Pulse period, cycles
    logic [23:0]         qcw_width;                            // Pulse width, cycles
    logic [IRQ_BITS-1:0] irq_stat;                             // Sticky events
    logic [IRQ_BITS-1:0] irq_en;                               // Event mask

    // Sequence state
    lsc_state_t  state;                                        // Output sequence
    logic [5:0]  sec_cnt;                                      // Elapsed delay seconds
    logic [31:0] tick_cnt;                                     // Cycles within a second
    logic        key_q;                                        // Previous key level
    logic        prot_latch;                                   // Protection-mode latch
    logic [31:0] alarm_cnt;                                    // Alarm cycles left
    logic [15:0] cp_level;                                     // Power-loop current

    // Derived terms
    logic        ilk_closed;                                   // Synchronised interlock
    logic        en_high;                                      // Synchronised enable
    logic [1:0]  inh;                                          // Inhibit mode
    logic        key_rise;                                     // New laser-on press
    logic        over_v;                                       // Overvoltage now
    logic        start_ok;                                     // Switch-on checks pass
    logic        delay_done;                                   // Delay elapsed
    logic        current_on;                                   // Current flowing
    logic        ev_ilk, ev_enf, ev_ov, ev_ref;                // Event terms, high while each condition holds
    logic [15:0] target_ma;                                    // Unclamped drive request
    logic [IRQ_BITS-1:0] events;                               // Events packed

    lsc_qcw_if qcw_bus ();

    // Enable idles high, interlock idles open
    lsc_sync #(.WIDTH(2), .RST_VAL(2'h2)) u_sync (
        .clock (clock),
        .rstn  (rstn),
        .d     ({external_enable_input, interlock_sense}),
        .q     ({en_high, ilk_closed})
    );

    // Pulse pattern generator
    lsc_qcw u_qcw (
        .clock (clock),
        .rstn  (rstn),
        .qcw   (qcw_bus.gen)
    );

    assign qcw_bus.enable = ctrl[CTRL_QCW_BIT] && current_on;
    assign qcw_bus.period = qcw_period;
    assign qcw_bus.width  = qcw_width;

    // Combinational checks and events
    assign inh        = ctrl[CTRL_INH_LSB +: 2];
    assign key_rise   = laser_on_key && !key_q;
    assign over_v     = laser_voltage_mv >= vprot_mv;
    assign start_ok   = ilk_closed && !over_v && !(inh == INH_PROT && !en_high);
    assign delay_done = (sec_cnt + 6'h01 >= delay_s) && (tick_cnt + 32'h1 >= SEC_COUNT);
    assign current_on = (state == ST_ON) && !(inh == INH_AUTO && !en_high);
    assign ev_ilk     = (state != ST_OFF) && !ilk_closed;
    assign ev_ov      = (state == ST_ON) && over_v;
    assign ev_enf     = (state != ST_OFF) && inh != INH_NONE && !en_high;
    assign ev_ref     = ((state == ST_OFF) && key_rise && !start_ok)
                      || ((state == ST_DELAY) && delay_done && !start_ok);
    assign events     = {ev_ref, ev_ov, ev_enf, ev_ilk};

    // Key edge memory
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            key_q <= 1'b0;
        end else begin
            key_q <= laser_on_key;
        end
    end

    // Output sequence
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= ST_OFF;
        end else begin
            unique case (state)
                ST_OFF: begin
                    if (key_rise && start_ok) begin
                        state <= (delay_s == 6'h00) ? ST_ON : ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    if (laser_off_key || !ilk_closed) begin
                        state <= ST_OFF;
                    end else if (delay_done) begin
                        state <= start_ok ? ST_ON : ST_OFF;
                    end
                end
                ST_ON: begin
                    if (!ilk_closed) begin
                        state <= ST_OFF;
                    end else if (over_v) begin
                        state <= ST_OFF;
                    end else if (inh == INH_PROT && !en_high) begin
                        state <= ST_OFF;
                    end else if (laser_off_key) begin
                        state <= ST_OFF;
                    end
                end
            endcase
        end
    end

    // Delay timer, runs only in the delay state
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sec_cnt  <= 6'h00;
            tick_cnt <= 32'h0;
        end else if (state != ST_DELAY) begin
            sec_cnt  <= 6'h00;
            tick_cnt <= 32'h0;
        end else if (tick_cnt + 32'h1 >= SEC_COUNT) begin
            tick_cnt <= 32'h0;
            sec_cnt  <= sec_cnt + 6'h01;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end

    // Protection latch, released only by a fresh key press
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            prot_latch <= 1'b0;
        end else if (state == ST_ON && inh == INH_PROT && !en_high) begin
            prot_latch <= 1'b1;
        end else if (key_rise) begin
            prot_latch <= 1'b0;
        end
    end

    // Alarm timer, loaded when interlock opens in the on state
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            alarm_cnt <= 32'h0;
        end else if (state == ST_ON && !ilk_closed) begin
            alarm_cnt <= ALARM_COUNT;
        end else if (alarm_cnt != 32'h0) begin
            alarm_cnt <= alarm_cnt - 32'h1;
        end
    end

    // Constant power loop: step current toward feedback setpoint
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cp_level <= 16'h0000;
        end else if (!current_on || !ctrl[CTRL_MODE_BIT]) begin
            cp_level <= 16'h0000;
        end else if (feedback_value < pwr_set && cp_level < ilim_ma) begin
            cp_level <= cp_level + 16'h0001;
        end else if (feedback_value > pwr_set && cp_level != 16'h0000) begin
            cp_level <= cp_level - 16'h0001;
        end
    end

    assign target_ma = ctrl[CTRL_MODE_BIT] ? cp_level : cur_set_ma;

    // Registered field outputs
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            interlock_drive   <= 1'b0;
            key_led_red       <= 1'b0;
            alarm_beep        <= 1'b0;
            error_flag        <= 1'b0;
            drive_pin_cathode <= 1'b0;
            drive_pin_anode   <= 1'b0;
            drive_current_ma  <= 16'h0000;
            trigger_out       <= 1'b0;
        end else begin
            interlock_drive   <= current_on;
            key_led_red       <= !ilk_closed;
            error_flag        <= !ilk_closed;
            alarm_beep        <= (alarm_cnt != 32'h0)
                               || (state == ST_ON && !ilk_closed);
            drive_pin_cathode <= current_on && !ctrl[CTRL_POL_BIT];
            drive_pin_anode   <= current_on && ctrl[CTRL_POL_BIT];
            drive_current_ma  <= !current_on ? 16'h0000
                               : (target_ma > ilim_ma) ? ilim_ma : target_ma;
            trigger_out       <= qcw_bus.trig;
        end
    end

    // Configuration writes
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl       <= CTRL_RESET;
            delay_s    <= DELAY_RESET_S;
            vprot_mv   <= VPROT_MAX_MV;
            ilim_ma    <= ILIM_TOP_MA;
            cur_set_ma <= 16'h0000;
            pwr_set    <= 16'h0000;
            qcw_period <= 24'h000000;
            qcw_width  <= 24'h000000;
            irq_en     <= '0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                REG_CTRL:       ctrl       <= reg_wdata[4:0];
                REG_DELAY:      delay_s    <= 6'(clamp16({10'h000, reg_wdata[5:0]}, 16'h0000,
                                                      {10'h000, DELAY_MAX_S}));
                REG_VPROT:      vprot_mv   <= clamp16(reg_wdata[15:0], VPROT_MIN_MV,
                                                      VPROT_MAX_MV);
                REG_ILIM:       ilim_ma    <= clamp16(reg_wdata[15:0], ILIM_MIN_MA,
                                                      ILIM_TOP_MA);
                REG_CUR_SET:    cur_set_ma <= reg_wdata[15:0];
                REG_PWR_SET:    pwr_set    <= reg_wdata[15:0];
                REG_QCW_PERIOD: qcw_period <= reg_wdata[23:0];
                REG_QCW_WIDTH:  qcw_width  <= reg_wdata[23:0];
                REG_IRQ_EN:     irq_en     <= reg_wdata[IRQ_BITS-1:0];
                default: ;
            endcase
        end
    end

    // Sticky status: a new event wins over a clear in the same cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= (irq_stat & ~((reg_wr && reg_addr == REG_IRQ_CLR)
                                      ? reg_wdata[IRQ_BITS-1:0] : '0)) | events;
        end
    end

    // Level interrupt
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_en);
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 32'h0;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h0;
        end else begin
            unique case (reg_addr)
                REG_CTRL:       reg_rdata <= {27'h0, ctrl};
                REG_DELAY:      reg_rdata <= {26'h0, delay_s};
                REG_VPROT:      reg_rdata <= {16'h0, vprot_mv};
                REG_ILIM:       reg_rdata <= {16'h0, ilim_ma};
                REG_CUR_SET:    reg_rdata <= {16'h0, cur_set_ma};
                REG_PWR_SET:    reg_rdata <= {16'h0, pwr_set};
                REG_QCW_PERIOD: reg_rdata <= {8'h0, qcw_period};
                REG_QCW_WIDTH:  reg_rdata <= {8'h0, qcw_width};
                REG_STATE:      reg_rdata <= {26'h0, prot_latch, en_high, ilk_closed,
                                              current_on, state};
                REG_IRQ_STAT:   reg_rdata <= {28'h0, irq_stat};
                REG_IRQ_EN:     reg_rdata <= {28'h0, irq_en};
                default:        reg_rdata <= 32'h0;
            endcase
        end
    end

endmodule : lsc_top

// [lsc_field_model.sv]
`timescale 1ns/1ps
module lsc_field_model (
    // Bench commands
    input  wire logic        loop_closed,
    input  wire logic        fault,
    input  wire logic        overvolt,
    // Laser side
    input  wire logic        interlock_drive,
    input  wire logic [15:0] drive_current_ma,
    output logic             interlock_sense,
    output logic             external_enable_input,
    output logic      [15:0] laser_voltage_mv,
    output logic      [15:0] feedback_value
);
    // Series switch chain
    assign interlock_sense = loop_closed;
    // Low on fault, pulled up when idle
    assign external_enable_input = fault ? 1'b0 : 1'b1;
    // Nominal 2 V, trip level above threshold
    assign laser_voltage_mv = overvolt ? 16'h0a28 : (interlock_drive ? 16'h07d0 : 16'h0000);
    // Photodiode sees half the current
    assign feedback_value = {1'b0, drive_current_ma[15:1]};
endmodule : lsc_field_model

// [lsc_top_assertions.sv]
`timescale 1ns/1ps
module lsc_top_assertions
    import lsc_pkg::*;
#(
    parameter logic [15:0] ILIM_TOP_MA = ILIM_MAX_MA
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rstn,
    // Watched pins
    input  wire logic        interlock_sense,
    input  wire logic        interlock_drive,
    input  wire logic        alarm_beep,
    input  wire logic        key_led_red,
    input  wire logic        error_flag,
    input  wire logic        drive_pin_cathode,
    input  wire logic        drive_pin_anode,
    input  wire logic [15:0] drive_current_ma,
    input  wire logic        trigger_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Loop open for three samples, alone or while on
    sequence seq_open3; !interlock_sense [*3]; endsequence
    sequence seq_on_open; interlock_drive ##0 seq_open3; endsequence
    chk_off_on_open: assert property (seq_open3 |-> ##[0:3] !interlock_drive)
        else $error("output stays on with loop open");
    chk_alarm_open: assert property (seq_on_open |-> ##[0:4] alarm_beep)
        else $error("no alarm on loop open");
    chk_sync_hold: assert property (
        interlock_drive && $fell(interlock_sense) |=> interlock_drive)
        else $error("loop sense used unsynchronised");
    chk_led_open: assert property (!interlock_sense [*4] |-> key_led_red)
        else $error("red key light off with loop open");
    chk_led_error: assert property (key_led_red == error_flag)
        else $error("error flag differs from red light");
    chk_pins_drive: assert property (
        (drive_pin_cathode | drive_pin_anode) == interlock_drive)
        else $error("drive pins differ from loop drive");
    chk_pins_excl: assert property (!(drive_pin_cathode && drive_pin_anode))
        else $error("both drive pins on");
    chk_zero_off: assert property (!interlock_drive |-> drive_current_ma == 16'h0000)
        else $error("current while off");
    chk_ilim_cap: assert property (drive_current_ma <= ILIM_TOP_MA)
        else $error("current above limit");
    chk_trig_off: assert property (
        !interlock_drive && !$past(interlock_drive) |-> !trigger_out)
        else $error("trigger while off");
endmodule : lsc_top_assertions
bind lsc_top lsc_top_assertions #(.ILIM_TOP_MA(ILIM_TOP_MA)) i_lsc_top_assertions (.clock, .rstn,
    .interlock_sense, .interlock_drive, .alarm_beep, .key_led_red, .error_flag,
    .drive_pin_cathode, .drive_pin_anode, .drive_current_ma, .trigger_out);

// [tb.sv]
`timescale 1ns/1ps
module tb
    import lsc_pkg::*;
;
    logic        clock, rstn, reg_wr, reg_rd, laser_on_key, laser_off_key;     // Bench drives
    logic        loop_closed, fault, overvolt;                                 // Field commands
    logic [7:0]  reg_addr;                                                     // Register address
    logic [31:0] reg_wdata, reg_rdata;                                         // Register data
    logic        interlock_sense, external_enable_input, interlock_drive, key_led_red;
    logic        alarm_beep, error_flag, drive_pin_cathode, drive_pin_anode, trigger_out, irq;
    logic [15:0] laser_voltage_mv, feedback_value, drive_current_ma;           // Analog words
    int          miscompares = 0, checks = 0, n;                               // Counters
    // Block under test, short counts
    lsc_top #(.SEC_COUNT(10), .ALARM_COUNT(5)) i_lsc_top (.clock, .rstn, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .laser_on_key, .laser_off_key, .interlock_sense,
        .external_enable_input, .laser_voltage_mv, .feedback_value, .interlock_drive,
        .key_led_red, .alarm_beep, .error_flag, .drive_pin_cathode, .drive_pin_anode,
        .drive_current_ma, .trigger_out, .irq);
    // Laser, switches and enable source
    lsc_field_model i_lsc_field_model (.loop_closed, .fault, .overvolt, .interlock_drive,
        .drive_current_ma, .interlock_sense, .external_enable_input, .laser_voltage_mv,
        .feedback_value);
    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // Wait edges, then settle at falling edge
    task cyc(input int c);
        repeat (c) @(posedge clock);
        @(negedge clock);
    endtask : cyc
    // Word compare
    task cmp32(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp32
    // Bit compare
    task cmp1(input logic g, input logic e);
        cmp32({31'h0, g}, {31'h0, e});
    endtask : cmp1
    // One-cycle write strobe
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    // Read, data checked in the following cycle
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        cmp32(reg_rdata, e);
    endtask : rd
    // Key pressed two cycles
    task press();
        @(posedge clock);
        laser_on_key <= 1'b1;
        repeat (2) @(posedge clock);
        laser_on_key <= 1'b0;
    endtask : press
    task note(input string s);
        $display("test %s end", s);
    endtask : note
    task results();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : results
    // Hang guard
    initial begin
        #500000;
        miscompares++;
        results();
    end
    // Test sequence
    initial begin
        {rstn, reg_wr, reg_rd, laser_on_key, laser_off_key, fault, overvolt} = 7'h00;
        {reg_addr, reg_wdata, loop_closed} = {40'h0, 1'b1};
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        cyc(3);
        rd(REG_DELAY, 32'h3);
        rd(REG_VPROT, 32'h2af8);
        rd(REG_ILIM, 32'h13ba);
        rd(8'h30, 32'h0);
        wr(REG_DELAY, 32'h3d);
        rd(REG_DELAY, 32'h3c);
        wr(REG_VPROT, 32'h64);
        rd(REG_VPROT, 32'h3e8);
        wr(REG_VPROT, 32'h9c4);
        wr(REG_CUR_SET, 32'h100);
        wr(REG_DELAY, 32'h2);
        note("registers");
        press();
        cyc(10);
        cmp1(interlock_drive, 1'b0);
        cyc(15);
        cmp1(interlock_drive, 1'b1);
        cmp32({16'h0, drive_current_ma}, 32'h100);
        note("delay");
        @(posedge clock);
        loop_closed <= 1'b0;
        cyc(2);
        cmp1(interlock_drive, 1'b1);
        cyc(4);
        cmp1(interlock_drive, 1'b0);
        cmp1(alarm_beep, 1'b1);
        cmp1(key_led_red & error_flag, 1'b1);
        press();
        cyc(3);
        cmp1(interlock_drive, 1'b0);
        rd(REG_IRQ_STAT, 32'h9);
        cmp1(irq, 1'b0);
        wr(REG_IRQ_EN, 32'h8);
        cyc(1);
        cmp1(irq, 1'b1);
        wr(REG_IRQ_CLR, 32'hf);
        rd(REG_IRQ_STAT, 32'h0);
        cmp1(irq, 1'b0);
        note("interlock");
        @(posedge clock);
        loop_closed <= 1'b1;
        wr(REG_DELAY, 32'h0);
        wr(REG_CTRL, 32'h4);
        press();
        cyc(2);
        cmp1(interlock_drive, 1'b1);
        @(posedge clock);
        fault <= 1'b1;
        cyc(5);
        cmp1(interlock_drive, 1'b0);
        @(posedge clock);
        fault <= 1'b0;
        cyc(5);
        cmp1(interlock_drive, 1'b1);
        wr(REG_CTRL, 32'h0);
        @(posedge clock);
        fault <= 1'b1;
        cyc(5);
        cmp1(interlock_drive, 1'b1);
        wr(REG_CTRL, 32'h8);
        cyc(5);
        cmp1(interlock_drive, 1'b0);
        @(posedge clock);
        fault <= 1'b0;
        cyc(5);
        cmp1(interlock_drive, 1'b0);
        press();
        cyc(2);
        cmp1(interlock_drive, 1'b1);
        note("inhibit");
        @(posedge clock);
        overvolt <= 1'b1;
        cyc(4);
        cmp1(interlock_drive, 1'b0);
        @(posedge clock);
        overvolt <= 1'b0;
        press();
        cyc(2);
        cmp1(drive_pin_cathode, 1'b1);
        wr(REG_CTRL, 32'h9);
        cyc(2);
        cmp1(drive_pin_anode & !drive_pin_cathode, 1'b1);
        wr(REG_CUR_SET, 32'h2000);
        cyc(2);
        cmp32({16'h0, drive_current_ma}, 32'h13ba);
        note("overvoltage polarity limit");
        wr(REG_QCW_PERIOD, 32'h4);
        wr(REG_QCW_WIDTH, 32'h2);
        wr(REG_CTRL, 32'h19);
        cyc(4);
        n = 0;
        repeat (8) begin
            cyc(0);
            n += (trigger_out === 1'b1) ? 1 : 0;
        end
        cmp32(n, 32'h4);
        wr(REG_CUR_SET, 32'h100);
        wr(REG_PWR_SET, 32'h90);
        wr(REG_CTRL, 32'hb);
        cyc(400);
        cmp32({16'h0, feedback_value}, 32'h90);
        @(posedge clock);
        laser_off_key <= 1'b1;
        cyc(3);
        cmp1(interlock_drive, 1'b0);
        note("pattern power off");
        results();
    end
endmodule : tb
